// ===== logic/rmb_fifo.sv
`timescale 1ns/1ps
module rmb_fifo #(
   parameter int WIDTH = 97,
   parameter int DEPTH = 8
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_ce,
   input wire logic i_in_valid,
   input wire logic [WIDTH-1:0] i_in_data,
   output logic o_in_ready,
   output logic o_out_valid,
   output logic [WIDTH-1:0] o_out_data,
   input wire logic i_out_ready
);
   localparam int PW = $clog2(DEPTH);
   typedef struct packed {
      logic [PW-1:0] wptr;
      logic [PW-1:0] rptr;
      logic [PW:0] cnt;
      logic ready;
   } rmb_fifo_s;

   rmb_fifo_s st;
   rmb_fifo_s next_st;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign push = i_ce && i_in_valid && st.ready;
   assign pop = i_ce && o_out_valid && i_out_ready;
   assign o_in_ready = st.ready;
   assign o_out_valid = (st.cnt != '0);
   assign o_out_data = mem[st.rptr];

   always_comb
   begin
      next_st = st;
      if (push)
      begin
         next_st.wptr = (st.wptr == PW'(DEPTH - 1)) ? '0 : st.wptr + 1'b1;
      end
      if (pop)
      begin
         next_st.rptr = (st.rptr == PW'(DEPTH - 1)) ? '0 : st.rptr + 1'b1;
      end
      next_st.cnt = st.cnt + {{PW{1'b0}}, push} - {{PW{1'b0}}, pop};
      // Registered ready keeps the source port glitch free
      next_st.ready = (next_st.cnt != (PW+1)'(DEPTH));
   end

   always_ff @(posedge i_clk or negedge i_rst_n)
   begin
      if (!i_rst_n)
      begin
         st <= '{wptr: '0, rptr: '0, cnt: '0, ready: 1'b0};
      end
      else if (i_ce)
      begin
         st <= next_st;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (push)
      begin
         mem[st.wptr] <= i_in_data;
      end
   end
endmodule // rmb_fifo

// ===== logic/rmb_mailbox.sv
`timescale 1ns/1ps
// Behaviour
// - In double-read mode a low-byte read of a pair latches its companion for the holding read.
// - Clearing pending and new-data for the first of two frames does not set them again.
// - A frame stored while new-data is set sets message-lost.
// - A frame stored while new-data is set sets remote-pending.
// - A third frame overwrites the older slot's identifier and keeps the newer slot's one.
// - From reset, before any frame, all four flags read 0 and the interrupt line is high.
// - A first frame sets new-data and pending and drives the interrupt low; others stay 0.
// - Clearing pending releases the interrupt line high even with a second frame unread.
module rmb_mailbox #(
   parameter int ID_W = rmb_pkg::ID_W,
   parameter int FIFO_DEPTH = rmb_pkg::FIFO_DEPTH
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST_N,
   input wire logic I_CE,
   input wire logic I_FRM_VALID,
   input wire logic [ID_W-1:0] I_FRM_ID,
   input wire logic [rmb_pkg::DLC_W-1:0] I_FRM_DLC,
   input wire logic [rmb_pkg::DATA_W-1:0] I_FRM_DATA,
   output logic O_FRM_READY,
   input wire logic I_STORE_HOLD,
   input wire logic I_RD,
   input wire logic [rmb_pkg::ADDR_W-1:0] I_RD_ADDR,
   input wire logic I_HS_RD,
   input wire logic I_DOUBLE_READ,
   input wire logic I_CLR_INT_PND,
   input wire logic I_CLR_NEW_DAT,
   input wire logic I_CLR_MSG_LST,
   input wire logic I_CLR_RMT_PND,
   output logic [7:0] O_RD_DATA,
   output logic O_RD_VALID,
   output logic O_INTERRUPT_PENDING_FLAG,
   output logic O_NEW_DATA_FLAG,
   output logic O_MESSAGE_LOST_FLAG,
   output logic O_REMOTE_PENDING_FLAG,
   output logic O_INT_N
);
   localparam int FW = ID_W + rmb_pkg::PAY_W;

   rmb_pkg::rmb_state_s st;
   rmb_pkg::rmb_state_s next_st;
   logic fifo_ready;
   logic frm_valid;
   logic [FW-1:0] frm_word;
   logic pop;
   logic id_we;
   logic id_addr;
   logic pay_we;
   logic pay_addr;
   logic [ID_W-1:0] mem_id;
   logic [rmb_pkg::PAY_W-1:0] mem_pay;
   logic [rmb_pkg::BYTES_W-1:0] frame_bytes;
   logic seen_store;

   // Store is held off while the host asks, so the FIFO takes the burst
   assign pop = I_CE && frm_valid && !I_STORE_HOLD;

   rmb_fifo #(
      .WIDTH(FW),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RST_N),
      .i_ce(I_CE),
      .i_in_valid(I_FRM_VALID),
      .i_in_data({I_FRM_ID, I_FRM_DLC, I_FRM_DATA}),
      .o_in_ready(fifo_ready),
      .o_out_valid(frm_valid),
      .o_out_data(frm_word),
      .i_out_ready(!I_STORE_HOLD)
   );

   rmb_slot_mem #(
      .ID_W(ID_W),
      .PAY_W(rmb_pkg::PAY_W),
      .DEPTH(rmb_pkg::SLOTS)
   ) u_mem (
      .i_clk(I_SYS_CLK),
      .i_ce(I_CE),
      .i_id_we(id_we),
      .i_id_addr(id_addr),
      .i_id(frm_word[FW-1 -: ID_W]),
      .i_pay_we(pay_we),
      .i_pay_addr(pay_addr),
      .i_pay(frm_word[rmb_pkg::PAY_W-1:0]),
      .i_rd_addr(next_st.rd_slot),
      .o_id(mem_id),
      .o_pay(mem_pay)
   );

   // Byte image of the older slot: identifier (4), length (1), data (8)
   assign frame_bytes = {32'(mem_id), 4'h0, mem_pay};
   assign O_FRM_READY = fifo_ready;
   assign O_RD_DATA = st.rd_data;
   assign O_RD_VALID = st.rd_valid;
   assign O_INTERRUPT_PENDING_FLAG = st.ip;
   assign O_NEW_DATA_FLAG = st.nd;
   assign O_MESSAGE_LOST_FLAG = st.ml;
   assign O_REMOTE_PENDING_FLAG = st.rp;
   assign O_INT_N = st.int_n;

   always_comb
   begin
      logic free;
      logic [rmb_pkg::BYTES_W-1:0] shifted;
      logic [1:0] cnt_mid;
      logic slot_mid;
      free = 1'b0;
      shifted = '0;
      cnt_mid = st.cnt;
      slot_mid = st.rd_slot;
      next_st = st;
      id_we = 1'b0;
      pay_we = 1'b0;
      id_addr = 1'b0;
      pay_addr = 1'b0;

      // Host acknowledges by writing flags to their reset value
      if (I_CLR_INT_PND)
      begin
         next_st.ip = rmb_pkg::FLAG_RESET;
      end
      if (I_CLR_MSG_LST)
      begin
         next_st.ml = rmb_pkg::FLAG_RESET;
      end
      if (I_CLR_RMT_PND)
      begin
         next_st.rp = rmb_pkg::FLAG_RESET;
      end
      if (I_CLR_NEW_DAT)
      begin
         next_st.nd = rmb_pkg::FLAG_RESET;
         // Clearing new-data retires the older slot; the next one is not flagged again
         free = (st.cnt != rmb_pkg::CNT_EMPTY);
      end
      if (free)
      begin
         cnt_mid = st.cnt - 2'd1;
         slot_mid = !st.rd_slot;
      end

      if (pop)
      begin
         if (cnt_mid == rmb_pkg::CNT_FULL)
         begin
            // Third frame: identifier lands in the older slot, payload in the newer
            id_we = 1'b1;
            id_addr = slot_mid;
            pay_we = 1'b1;
            pay_addr = !slot_mid;
         end
         else
         begin
            id_we = 1'b1;
            pay_we = 1'b1;
            id_addr = slot_mid ^ cnt_mid[0];
            pay_addr = slot_mid ^ cnt_mid[0];
            cnt_mid = cnt_mid + 2'd1;
         end
         // Setting wins over a clear in the same cycle
         if (st.nd)
         begin
            next_st.ml = 1'b1;
            next_st.rp = 1'b1;
         end
         else
         begin
            next_st.nd = 1'b1;
            next_st.ip = 1'b1;
         end
         next_st.nd = next_st.nd | st.nd;
      end
      next_st.cnt = cnt_mid;
      next_st.rd_slot = slot_mid;
      next_st.int_n = !next_st.ip;

      next_st.rd_valid = I_RD || I_HS_RD;
      if (I_HS_RD)
      begin
         shifted = frame_bytes << {st.hold_addr, 3'b000};
         next_st.rd_data = st.hold_ok ? shifted[rmb_pkg::BYTES_W-1 -: 8] : rmb_pkg::BYTE_ZERO;
         next_st.hold_ok = 1'b0;
      end
      else if (I_RD)
      begin
         shifted = frame_bytes << {I_RD_ADDR, 3'b000};
         next_st.rd_data = (I_RD_ADDR <= rmb_pkg::LAST_BYTE) ?
            shifted[rmb_pkg::BYTES_W-1 -: 8] : rmb_pkg::BYTE_ZERO;
         // Holds the index, not the byte: a store before the holding read shows the new byte
         if (I_DOUBLE_READ && !I_RD_ADDR[0] && I_RD_ADDR < rmb_pkg::LAST_BYTE)
         begin
            next_st.hold_addr = I_RD_ADDR + 4'h1;
            next_st.hold_ok = 1'b1;
         end
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         st <= '{cnt: rmb_pkg::CNT_EMPTY, rd_slot: 1'b0, ip: rmb_pkg::FLAG_RESET,
                 nd: rmb_pkg::FLAG_RESET, ml: rmb_pkg::FLAG_RESET, rp: rmb_pkg::FLAG_RESET,
                 int_n: rmb_pkg::INT_N_IDLE, rd_data: rmb_pkg::BYTE_ZERO, rd_valid: 1'b0,
                 hold_addr: '0, hold_ok: 1'b0};
      end
      else if (I_CE)
      begin
         st <= next_st;
      end
   end

   always_ff @(posedge I_SYS_CLK or negedge I_RST_N)
   begin
      if (!I_RST_N)
      begin
         seen_store <= 1'b0;
      end
      else if (pop)
      begin
         seen_store <= 1'b1;
      end
   end

   a_reset_idle_flags: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      !seen_store |-> (!st.ip && !st.nd && !st.ml && !st.rp && O_INT_N))
      else $error("Flags not idle before first frame");

   a_first_frame_flags: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && !st.nd && !st.ml && !st.rp && !I_CLR_INT_PND) |=>
         (st.nd && st.ip && !O_INT_N && !st.ml && !st.rp))
      else $error("First frame did not raise new data and interrupt");

   a_second_sets_lost: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && st.nd) |=> (st.ml && st.nd))
      else $error("Message lost not set on second frame");

   a_second_sets_remote: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && st.nd) |=> st.rp)
      else $error("Remote pending not set on second frame");

   a_no_flag_reassert: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_CLR_NEW_DAT && (I_CLR_INT_PND || !st.ip) && st.cnt == 2'd2 &&
         !frm_valid && !I_FRM_VALID) |=>
         (!st.nd && !st.ip) [*2])
      else $error("Flags set again for second buffered frame");

   a_clear_releases_int: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_CLR_INT_PND && !I_CLR_NEW_DAT && !pop) |=> (!st.ip && O_INT_N && $stable(st.cnt)))
      else $error("Interrupt not released by pending clear");

   a_third_keeps_id: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && st.cnt == 2'd2 && !I_CLR_NEW_DAT) |->
         (id_we && id_addr == st.rd_slot && pay_addr != st.rd_slot))
      else $error("Third frame identifier placed wrongly");

   a_double_read_latch: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_RD && !I_HS_RD && I_DOUBLE_READ && !I_RD_ADDR[0] && I_RD_ADDR < 4'd12) |=>
         (st.hold_ok && st.hold_addr == $past(I_RD_ADDR) + 4'd1 && O_RD_VALID))
      else $error("Companion byte not latched");

   a_older_slot_first: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_CLR_NEW_DAT && st.cnt == 2'd2 && !pop) |=>
         (st.cnt == 2'd1 && st.rd_slot != $past(st.rd_slot)))
      else $error("Slot not advanced to the newer frame");

   a_lost_needs_store: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (!st.ml && !pop) |=> !st.ml)
      else $error("Message lost rose without a store");

   a_remote_needs_store: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (!st.rp && !pop) |=> !st.rp)
      else $error("Remote pending rose without a store");

   a_pending_only_first: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (!st.ip && !(pop && !st.nd)) |=> !st.ip)
      else $error("Pending set without a first frame");

   a_hold_read_empty: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_HS_RD && !st.hold_ok) |=> (O_RD_VALID && O_RD_DATA == rmb_pkg::BYTE_ZERO))
      else $error("Empty holding read returned data");

   a_third_keeps_count: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && st.cnt == 2'd2 && !I_CLR_NEW_DAT) |=> (st.cnt == 2'd2 && $stable(st.rd_slot)))
      else $error("Third frame changed slot count or order");

   a_first_frame_slot: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (pop && st.cnt == rmb_pkg::CNT_EMPTY) |->
         (id_we && pay_we && id_addr == st.rd_slot && pay_addr == st.rd_slot))
      else $error("First frame not written to the read slot");

   a_read_past_end: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      (I_CE && I_RD && !I_HS_RD && I_RD_ADDR > rmb_pkg::LAST_BYTE) |=>
         (O_RD_VALID && O_RD_DATA == rmb_pkg::BYTE_ZERO))
      else $error("Read beyond the frame image not zero");

   a_enable_freezes: assert property (@(posedge I_SYS_CLK) disable iff (!I_RST_N)
      !I_CE |=> $stable(st))
      else $error("State moved while clock enable was low");
endmodule // rmb_mailbox

// ===== logic/rmb_pkg.sv
package rmb_pkg;
   localparam int ID_W = 29;
   localparam int DLC_W = 4;
   localparam int DATA_W = 64;
   localparam int PAY_W = DLC_W + DATA_W;
   localparam int FRAME_W = ID_W + PAY_W;
   localparam int SLOTS = 2;
   localparam int FIFO_DEPTH = 8;
   localparam int ADDR_W = 4;
   localparam int BYTES_W = 104;
   localparam logic [ADDR_W-1:0] LAST_BYTE = 4'hc;
   localparam logic [1:0] CNT_EMPTY = 2'h0;
   localparam logic [1:0] CNT_FULL = 2'h2;
   localparam logic FLAG_RESET = 1'b0;
   localparam logic INT_N_IDLE = 1'b1;
   localparam logic [7:0] BYTE_ZERO = 8'h00;

   typedef struct packed {
      logic [1:0] cnt;
      logic rd_slot;
      logic ip;
      logic nd;
      logic ml;
      logic rp;
      logic int_n;
      logic [7:0] rd_data;
      logic rd_valid;
      logic [ADDR_W-1:0] hold_addr;
      logic hold_ok;
   } rmb_state_s;
endpackage

// ===== logic/rmb_slot_mem.sv
`timescale 1ns/1ps
module rmb_slot_mem #(
   parameter int ID_W = 29,
   parameter int PAY_W = 68,
   parameter int DEPTH = 2
) (
   input wire logic i_clk,
   input wire logic i_ce,
   input wire logic i_id_we,
   input wire logic [$clog2(DEPTH)-1:0] i_id_addr,
   input wire logic [ID_W-1:0] i_id,
   input wire logic i_pay_we,
   input wire logic [$clog2(DEPTH)-1:0] i_pay_addr,
   input wire logic [PAY_W-1:0] i_pay,
   input wire logic [$clog2(DEPTH)-1:0] i_rd_addr,
   output logic [ID_W-1:0] o_id,
   output logic [PAY_W-1:0] o_pay
);
   // Identifier and payload are written apart so one can move without the other
   logic [ID_W-1:0] id_mem [DEPTH];
   logic [PAY_W-1:0] pay_mem [DEPTH];

   always_ff @(posedge i_clk)
   begin
      if (i_ce)
      begin
         if (i_id_we)
         begin
            id_mem[i_id_addr] <= i_id;
         end
         if (i_pay_we)
         begin
            pay_mem[i_pay_addr] <= i_pay;
         end
         o_id <= id_mem[i_rd_addr];
         o_pay <= pay_mem[i_rd_addr];
      end
   end
endmodule // rmb_slot_mem

// ===== tb/rmb_frame_src.sv
`timescale 1ns/1ps
module rmb_frame_src (
   input wire logic i_clk,
   input wire logic i_ready,
   output logic o_valid,
   output logic [rmb_pkg::ID_W-1:0] o_id,
   output logic [rmb_pkg::DLC_W-1:0] o_dlc,
   output logic [rmb_pkg::DATA_W-1:0] o_data
);
   initial
   begin
      o_valid = 1'b0;
      o_id = '0;
      o_dlc = '0;
      o_data = '0;
   end

   // Offer held whole until ready is seen at a sampling edge
   task automatic offer(input logic [rmb_pkg::ID_W-1:0] id, input logic [3:0] dlc,
      input logic [63:0] data);
      @(posedge i_clk);
      o_valid <= 1'b1;
      o_id <= id;
      o_dlc <= dlc;
      o_data <= data;
      @(negedge i_clk);
      while (i_ready !== 1'b1)
         @(negedge i_clk);
      @(posedge i_clk);
      o_valid <= 1'b0;
      // Released lines show the inverse so stale values never look valid
      o_id <= ~id;
      o_dlc <= ~dlc;
      o_data <= ~data;
   endtask
endmodule // rmb_frame_src

// ===== tb/tb.sv
`timescale 1ns/1ps
module tb;
   logic clk, rst_n, hold, rd, hs, dbl, c_ip, c_nd, c_ml, c_rp, ce;
   logic valid, ready, rdv, ip, nd, ml, rp, int_n;
   logic [3:0] addr;
   logic [rmb_pkg::ID_W-1:0] id, i1, i2;
   logic [rmb_pkg::DLC_W-1:0] dlc;
   logic [rmb_pkg::DATA_W-1:0] dat, d1, d2;
   logic [7:0] rdd, b;
   int err_total = 0;
   int tests_run = 0;
   int seed = 32'h215c_e623;

   rmb_frame_src SRC (.i_clk(clk), .i_ready(ready), .o_valid(valid), .o_id(id),
      .o_dlc(dlc), .o_data(dat));
   rmb_mailbox DUT (.I_SYS_CLK(clk), .I_RST_N(rst_n), .I_CE(ce), .I_FRM_VALID(valid),
      .I_FRM_ID(id), .I_FRM_DLC(dlc), .I_FRM_DATA(dat), .O_FRM_READY(ready),
      .I_STORE_HOLD(hold), .I_RD(rd), .I_RD_ADDR(addr), .I_HS_RD(hs),
      .I_DOUBLE_READ(dbl), .I_CLR_INT_PND(c_ip), .I_CLR_NEW_DAT(c_nd),
      .I_CLR_MSG_LST(c_ml), .I_CLR_RMT_PND(c_rp), .O_RD_DATA(rdd), .O_RD_VALID(rdv),
      .O_INTERRUPT_PENDING_FLAG(ip), .O_NEW_DATA_FLAG(nd), .O_MESSAGE_LOST_FLAG(ml),
      .O_REMOTE_PENDING_FLAG(rp), .O_INT_N(int_n));

   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end

   task automatic close_out();
      $display("checks=%0d errors=%0d", tests_run, err_total);
      if (err_total == 0 && tests_run > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         err_total++;
         $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask

   task automatic rst();
      @(posedge clk);
      rst_n <= 1'b0;
      cyc(6);
      rst_n <= 1'b1;
      cyc(2);
   endtask

   // Order matches the table columns: remote, new, lost, pending, line
   task automatic flags(input logic [4:0] exp);
      @(negedge clk);
      chk({3'h0, rp, nd, ml, ip, int_n}, {3'h0, exp});
   endtask

   // Mask bits: 8 remote, 4 new data, 2 lost, 1 pending
   task automatic clr(input logic [3:0] m);
      @(posedge clk);
      {c_rp, c_nd, c_ml, c_ip} <= m;
      @(posedge clk);
      {c_rp, c_nd, c_ml, c_ip} <= 4'h0;
      cyc(2);
   endtask

   // Host strobes launch from the rising edge only, clear of the sampling edge
   task automatic rdb(input logic [3:0] a, input logic h, output logic [7:0] v);
      @(posedge clk);
      rd <= ~h;
      hs <= h;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      hs <= 1'b0;
      @(negedge clk);
      chk({7'h00, rdv}, 8'h01);
      v = rdd;
   endtask

   function automatic logic [7:0] eb(input logic [3:0] a, input logic [28:0] i,
      input logic [3:0] l, input logic [63:0] d);
      logic [31:0] w;
      w = 32'(i);
      if (a < 4)
         return w[31-8*a -: 8];
      if (a == 4)
         return {4'h0, l};
      if (a < 13)
         return d[63-8*(a-5) -: 8];
      return 8'h00;
   endfunction

   // Whole frame is fetched, plus the zero byte past its end at address 13
   task automatic rdf(input logic [28:0] i, input logic [3:0] l, input logic [63:0] d);
      logic [7:0] v;
      for (int a = 0; a < 14; a++)
      begin
         rdb(4'(a), 1'b0, v);
         chk(v, eb(4'(a), i, l, d));
      end
   endtask

   initial
   begin
      #80_000;
      err_total++;
      close_out();
   end

   initial
   begin
      {rst_n, hold, rd, hs, dbl, c_ip, c_nd, c_ml, c_rp} = 9'h000;
      addr = 4'h0;
      ce = 1'b1;
      rst();
      flags(5'b0_0001);
      i1 = 29'($random(seed));
      i2 = 29'($random(seed));
      d1 = {$random(seed), $random(seed)};
      d2 = {$random(seed), $random(seed)};
      SRC.offer(i1, 4'h8, d1);
      cyc(3);
      flags(5'b0_1010);
      SRC.offer(i2, 4'h5, d2);
      cyc(3);
      flags(5'b1_1110);
      rdf(i1, 4'h8, d1);
      @(posedge clk);
      dbl <= 1'b1;
      rdb(4'h2, 1'b0, b);
      chk(b, eb(4'h2, i1, 4'h8, d1));
      rdb(4'h0, 1'b1, b);
      chk(b, eb(4'h3, i1, 4'h8, d1));
      // Holding register is spent after one read
      rdb(4'h0, 1'b1, b);
      chk(b, 8'h00);
      clr(4'h1);
      flags(5'b1_1101);
      clr(4'h8);
      flags(5'b0_1101);
      clr(4'h4);
      flags(5'b0_0101);
      rdf(i2, 4'h5, d2);
      clr(4'h2);
      flags(5'b0_0001);
      // Three frames before service: deliberately past the system limit
      rst();
      flags(5'b0_0001);
      SRC.offer(29'h111, 4'h4, 64'h0001_0203_0000_0000);
      SRC.offer(29'h222, 4'h5, 64'h0405_0607_0800_0000);
      SRC.offer(29'h333, 4'h6, 64'h090a_0b0c_0d0e_0000);
      cyc(3);
      rdf(29'h333, 4'h4, 64'h0001_0203_0000_0000);
      clr(4'h4);
      rdf(29'h222, 4'h6, 64'h090a_0b0c_0d0e_0000);
      // Stalled store path lets the queue fill until it refuses
      rst();
      @(posedge clk);
      hold <= 1'b1;
      repeat (8) SRC.offer(29'($random(seed)), 4'h8, {$random(seed), $random(seed)});
      cyc(2);
      @(negedge clk);
      chk({7'h00, ready}, 8'h00);
      @(posedge clk);
      hold <= 1'b0;
      cyc(12);
      @(negedge clk);
      chk({7'h00, ready}, 8'h01);
      flags(5'b1_1110);
      // Clock enable low must swallow a clear pulse
      @(posedge clk);
      ce <= 1'b0;
      clr(4'h1);
      flags(5'b1_1110);
      @(posedge clk);
      ce <= 1'b1;
      clr(4'h1);
      flags(5'b1_1101);
      close_out();
   end
endmodule // tb
